// ==== common/fsk_pkg.sv ====
package fsk_pkg;
    // Register indexes; the bus byte address is four times the index.
    localparam logic [15:0] IDX_WORK_OPT = 16'h1821;
    localparam logic [15:0] IDX_FLASH_CFG = 16'h1823;
    localparam logic [15:0] IDX_WORK_PROT = 16'h1824;
    localparam logic [15:0] IDX_SEC_STATUS = 16'h1830;
    localparam logic [15:0] IDX_KEY_BASE = 16'hFFB0;
    localparam logic [15:0] IDX_KEY_LAST = 16'hFFB7;
    localparam logic [15:0] IDX_NV_PROT = 16'hFFBD;
    localparam logic [15:0] IDX_NV_OPT = 16'hFFBF;
    // Field positions.
    localparam int OPT_KEY_ENABLE_BIT_BIT = 7;
    localparam int OPT_NORED_BIT = 6;
    localparam int CFG_KEY_WRITE_ACCESS_BIT = 5;
    localparam int PROT_DIS_BIT = 0;
    localparam int STAT_SECURED_BIT = 0;
    localparam int STAT_UNLOCK_BIT = 1;
    localparam int STAT_KEYFAIL_BIT = 2;
    localparam int STAT_REFUSED_BIT = 3;
    localparam int STAT_LOADED_BIT = 4;
    localparam int STAT_BLANK_BIT = 5;
    // Reset values; the option reset value keeps the part secured while loading.
    localparam logic [7:0] OPT_RESET = 8'h03;
    localparam logic [7:0] PROT_RESET = 8'hFF;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    // Array command codes.
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_PROGRAM = 8'h20;
    localparam logic [7:0] CMD_BURST = 8'h25;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
    // Loader sequencing: eight key bytes, then protect byte, then option byte.
    localparam int KEY_BYTES = 8;
    localparam logic [3:0] LOAD_PROT_STEP = 4'h8;
    localparam logic [3:0] LOAD_LAST_STEP = 4'h9;

    typedef enum logic [1:0] {
        LD_FETCH = 2'b00,
        LD_DONE = 2'b01
    } fsk_load_state_type;

    function automatic logic fsk_is_secured(input logic [1:0] secField);
        return secField != SEC_UNSECURED;
    endfunction
endpackage

// ==== common/fsk_link_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// Carries loaded array contents and the key comparison between the modules.
interface fsk_link_if;
    logic loadStrobe;
    logic loadDone;
    logic [63:0] storedKey;
    logic [7:0] storedProt;
    logic [7:0] storedOpt;
    logic [63:0] enteredKey;
    logic keyMatch;

    modport loader (
        output loadStrobe, loadDone, storedKey, storedProt, storedOpt
    );
    modport cmp (
        input storedKey, enteredKey,
        output keyMatch
    );
    modport top (
        input loadStrobe, loadDone, storedProt, storedOpt, keyMatch,
        output enteredKey
    );
endinterface
`default_nettype wire

// ==== design/fsk_key_compare.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsk_key_compare (
    // Key pair to compare.
    fsk_link_if.cmp lnk
);
    logic [fsk_pkg::KEY_BYTES-1:0] byteEq;

    always_comb begin
        for (int i = 0; i < fsk_pkg::KEY_BYTES; i++) begin
            byteEq[i] = lnk.storedKey[i*8 +: 8] == lnk.enteredKey[i*8 +: 8];
        end
    end

    // A single differing byte is enough to refuse the key.
    assign lnk.keyMatch = &byteEq;
endmodule
`default_nettype wire

// ==== design/fsk_nv_loader.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsk_nv_loader (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Array read port.
    output logic nvRdReq,
    output logic [15:0] nvRdAddr,
    input wire logic [7:0] nvRdData,
    input wire logic nvRdValid,
    // Loaded contents.
    fsk_link_if.loader lnk
);
    fsk_pkg::fsk_load_state_type state_q;
    logic [3:0] step_q;
    logic [7:0] keyMem [fsk_pkg::KEY_BYTES];
    logic [7:0] prot_q;
    logic [7:0] opt_q;
    logic strobe_q;
    logic gotByte;

    assign nvRdAddr = (step_q == fsk_pkg::LOAD_LAST_STEP) ? fsk_pkg::IDX_NV_OPT :
        (step_q == fsk_pkg::LOAD_PROT_STEP) ? fsk_pkg::IDX_NV_PROT :
        fsk_pkg::IDX_KEY_BASE + {13'h0000, step_q[2:0]};
    assign nvRdReq = state_q == fsk_pkg::LD_FETCH;
    assign gotByte = nvRdReq & nvRdValid;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= fsk_pkg::LD_FETCH;
            step_q <= 4'h0;
            prot_q <= fsk_pkg::PROT_RESET;
            opt_q <= fsk_pkg::OPT_RESET;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= gotByte & (step_q == fsk_pkg::LOAD_LAST_STEP);
            if (gotByte & (step_q == fsk_pkg::LOAD_PROT_STEP)) prot_q <= nvRdData;
            if (gotByte & (step_q == fsk_pkg::LOAD_LAST_STEP)) opt_q <= nvRdData;
            if (gotByte & (step_q == fsk_pkg::LOAD_LAST_STEP)) begin
                state_q <= fsk_pkg::LD_DONE;
            end else if (gotByte) begin
                step_q <= step_q + 4'h1;
            end
        end
    end

    // Key storage is plain data and needs no reset.
    always_ff @(posedge ref_clk) begin
        if (gotByte & ~step_q[3]) keyMem[step_q[2:0]] <= nvRdData;
    end

    always_comb begin
        for (int i = 0; i < fsk_pkg::KEY_BYTES; i++) begin
            lnk.storedKey[i*8 +: 8] = keyMem[i];
        end
    end

    assign lnk.storedProt = prot_q;
    assign lnk.storedOpt = opt_q;
    assign lnk.loadStrobe = strobe_q;
    assign lnk.loadDone = state_q == fsk_pkg::LD_DONE;
endmodule
`default_nettype wire

// ==== design/fsk_security_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsk_security_unit (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Origin of the current bus access.
    input wire logic busFromDebug,
    input wire logic busCodeSecure,
    // Nonvolatile array read port.
    output logic nvRdReq,
    output logic [15:0] nvRdAddr,
    input wire logic [7:0] nvRdData,
    input wire logic nvRdValid,
    // RAM access gate.
    input wire logic ramReq,
    input wire logic ramFromDebug,
    input wire logic ramFromSecureCode,
    output logic ramAllow,
    // Background debug array command check.
    input wire logic dbgCmdValid,
    input wire logic [7:0] dbgCmdCode,
    output logic dbgCmdAccept,
    output logic dbgCmdAccessErr,
    // Results reported by the array command engine.
    input wire logic massEraseDone,
    input wire logic blankCheckPass,
    // Working options toward the array.
    output logic securedOut,
    output logic [6:0] protectStartField,
    output logic protectDisableBit,
    output logic vectorRedirectDisable
);
    fsk_link_if lnk();

    // Array loader and key comparator.
    fsk_nv_loader uLoader (
        .ref_clk(ref_clk),
        .reset(reset),
        .nvRdReq(nvRdReq),
        .nvRdAddr(nvRdAddr),
        .nvRdData(nvRdData),
        .nvRdValid(nvRdValid),
        .lnk(lnk.loader)
    );

    fsk_key_compare uCompare (
        .lnk(lnk.cmp)
    );

    // Working and status state.
    logic [7:0] workingOption_q;
    logic [7:0] workingProtect_q;
    logic keyWriteAccess_q;
    logic [7:0] keyByte_q [fsk_pkg::KEY_BYTES];
    logic [fsk_pkg::KEY_BYTES-1:0] keyWritten_q;
    logic keyUnlocked_q;
    logic keyFail_q;
    logic keyFail_d;
    logic keyRefused_q;
    logic keyRefused_d;
    logic massErased_q;
    logic blankUnsecured_q;
    logic ack_q;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic dbgAccept_q;
    logic dbgErr_q;

    // Bus decode; one aligned word per byte-wide register.
    wire logic [15:0] regIndex = wb_adr_i[17:2];
    wire logic busReq = wb_cyc_i & wb_stb_i;
    wire logic busTake = busReq & ack_q;
    wire logic busWr = busTake & wb_we_i & wb_sel_i[0];
    wire logic hitOpt = regIndex == fsk_pkg::IDX_WORK_OPT;
    wire logic hitCfg = regIndex == fsk_pkg::IDX_FLASH_CFG;
    wire logic hitProt = regIndex == fsk_pkg::IDX_WORK_PROT;
    wire logic hitStat = regIndex == fsk_pkg::IDX_SEC_STATUS;
    wire logic hitNvProt = regIndex == fsk_pkg::IDX_NV_PROT;
    wire logic hitNvOpt = regIndex == fsk_pkg::IDX_NV_OPT;
    wire logic hitKey = (regIndex >= fsk_pkg::IDX_KEY_BASE)
        & (regIndex <= fsk_pkg::IDX_KEY_LAST);
    wire logic [2:0] keySlot = regIndex[2:0];
    wire logic [7:0] wrByte = wb_dat_i[7:0];

    // Security state; the field decode lives in the package function.
    wire logic keyEnabled = workingOption_q[fsk_pkg::OPT_KEY_ENABLE_BIT_BIT];
    wire logic fieldSecured = fsk_pkg::fsk_is_secured(workingOption_q[1:0]);
    wire logic secured = fieldSecured & ~keyUnlocked_q & ~blankUnsecured_q;

    // Key entry from trusted code only.
    wire logic trustedWriter = ~busFromDebug & busCodeSecure;
    wire logic cfgWrite = busWr & hitCfg;
    wire logic newKeyAccess = wrByte[fsk_pkg::CFG_KEY_WRITE_ACCESS_BIT];
    wire logic keyAccessSet = cfgWrite & newKeyAccess & trustedWriter & keyEnabled;
    wire logic keyAccessEnd = cfgWrite & ~newKeyAccess & keyWriteAccess_q;
    wire logic keyByteWr = busWr & hitKey & keyWriteAccess_q & trustedWriter;
    wire logic keyRefusedNow = busWr & busFromDebug & (hitKey | (hitCfg & newKeyAccess));
    wire logic keyPass = keyAccessEnd & keyEnabled & (&keyWritten_q) & lnk.keyMatch;
    wire logic keyFailNow = keyAccessEnd & ~keyPass;

    // Debug command classification.
    wire logic cmdBlank = dbgCmdCode == fsk_pkg::CMD_BLANK;
    wire logic cmdMass = dbgCmdCode == fsk_pkg::CMD_MASS_ERASE;
    wire logic cmdKnown = cmdBlank | cmdMass | (dbgCmdCode == fsk_pkg::CMD_PROGRAM)
        | (dbgCmdCode == fsk_pkg::CMD_BURST) | (dbgCmdCode == fsk_pkg::CMD_PAGE_ERASE);
    wire logic cmdRefused = ~cmdKnown | (secured & ~(cmdBlank | cmdMass));

    // Status write-one-to-clear masks for the sticky key flags.
    wire logic statWr = busWr & hitStat;
    wire logic clrKeyFail = statWr & wrByte[fsk_pkg::STAT_KEYFAIL_BIT];
    wire logic clrRefused = statWr & wrByte[fsk_pkg::STAT_REFUSED_BIT];

    // A new event wins over a clear issued in the same cycle.
    assign keyFail_d = keyFailNow | (keyFail_q & ~clrKeyFail);
    assign keyRefused_d = keyRefusedNow | (keyRefused_q & ~clrRefused);

    // Entered key bytes go to the comparator.
    always_comb begin
        for (int i = 0; i < fsk_pkg::KEY_BYTES; i++) begin
            lnk.enteredKey[i*8 +: 8] = keyByte_q[i];
        end
    end

    // Read data select; unmapped indexes read as zero.
    always_comb begin
        rdData_d = 8'h00;
        if (hitOpt) rdData_d = workingOption_q;
        if (hitCfg) rdData_d = {2'h0, keyWriteAccess_q, 5'h00};
        if (hitProt) rdData_d = workingProtect_q;
        if (hitNvProt) rdData_d = lnk.storedProt;
        if (hitNvOpt) rdData_d = lnk.storedOpt;
        if (hitStat) begin
            rdData_d[fsk_pkg::STAT_SECURED_BIT] = secured;
            rdData_d[fsk_pkg::STAT_UNLOCK_BIT] = keyUnlocked_q;
            rdData_d[fsk_pkg::STAT_KEYFAIL_BIT] = keyFail_q;
            rdData_d[fsk_pkg::STAT_REFUSED_BIT] = keyRefused_q;
            rdData_d[fsk_pkg::STAT_LOADED_BIT] = lnk.loadDone;
            rdData_d[fsk_pkg::STAT_BLANK_BIT] = blankUnsecured_q;
        end
    end

    // Bus answer: ack one cycle after the request is seen, dropped after one cycle.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_q <= 1'b0;
            rdData_q <= 8'h00;
        end else begin
            ack_q <= busReq & ~ack_q;
            if (busReq & ~ack_q) rdData_q <= rdData_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = {24'h000000, rdData_q};

    // Working option register is read-only and only the loader fills it.
    // reload on reset.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            workingOption_q <= fsk_pkg::OPT_RESET;
        end else if (lnk.loadStrobe) begin
            workingOption_q <= lnk.storedOpt;
        end
    end

    // Working protect register: loaded at reset, then software may adjust it.
    // protect copy.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            workingProtect_q <= fsk_pkg::PROT_RESET;
        end else if (lnk.loadStrobe) begin
            workingProtect_q <= lnk.storedProt;
        end else if (busWr & hitProt) begin
            workingProtect_q <= wrByte;
        end
    end

    // Key write access opens only for trusted code with the key enabled.
    // access window.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            keyWriteAccess_q <= fsk_pkg::CFG_RESET[fsk_pkg::CFG_KEY_WRITE_ACCESS_BIT];
            keyWritten_q <= '0;
        end else if (keyAccessSet) begin
            keyWriteAccess_q <= 1'b1;
            keyWritten_q <= '0;
        end else if (keyAccessEnd) begin
            keyWriteAccess_q <= 1'b0;
        end else if (keyByteWr) begin
            keyWritten_q[keySlot] <= 1'b1;
        end
    end

    // Entered key bytes are data only; the written mask qualifies them.
    always_ff @(posedge ref_clk) begin
        if (keyByteWr) keyByte_q[keySlot] <= wrByte;
    end

    // Unlock lasts until the next reset; a failed key leaves security engaged.
    // key unlock.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            keyUnlocked_q <= 1'b0;
            keyFail_q <= 1'b0;
            keyRefused_q <= 1'b0;
        end else begin
            if (keyPass) keyUnlocked_q <= 1'b1;
            keyFail_q <= keyFail_d;
            keyRefused_q <= keyRefused_d;
        end
    end

    // Erase then blank verify is the only way out without the key.
    // erase and verify.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            massErased_q <= 1'b0;
            blankUnsecured_q <= 1'b0;
        end else begin
            if (massEraseDone) massErased_q <= 1'b1;
            if (blankCheckPass & massErased_q) blankUnsecured_q <= 1'b1;
        end
    end

    // Debug command verdicts are registered one-cycle pulses.
    // access error flag.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dbgAccept_q <= 1'b0;
            dbgErr_q <= 1'b0;
        end else begin
            dbgAccept_q <= dbgCmdValid & ~cmdRefused;
            dbgErr_q <= dbgCmdValid & cmdRefused;
        end
    end

    assign dbgCmdAccept = dbgAccept_q;
    assign dbgCmdAccessErr = dbgErr_q;

    // RAM gate is combinational so the core sees no extra wait state.
    // RAM blocking.
    assign ramAllow = ramReq & (~secured | (~ramFromDebug & ramFromSecureCode));

    // Working options toward the array; security stays engaged until loading ends.
    assign securedOut = secured;
    assign protectStartField = workingProtect_q[7:1];
    assign protectDisableBit = workingProtect_q[fsk_pkg::PROT_DIS_BIT];
    assign vectorRedirectDisable = workingOption_q[fsk_pkg::OPT_NORED_BIT];
endmodule
`default_nettype wire

// ==== testbench/fsk_nv_array_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsk_nv_array_model (
    // Clock.
    input wire logic ref_clk,
    // Array read port.
    input wire logic nvRdReq,
    input wire logic [15:0] nvRdAddr,
    output logic [7:0] nvRdData,
    output logic nvRdValid,
    // Stored option byte and answer delay.
    input wire logic [7:0] optByte,
    input wire logic [1:0] lag
);
    logic [1:0] waitCnt_q = 2'h0;
    logic [3:0] keyNib;
    logic [7:0] byteVal;
    assign keyNib = nvRdAddr[3:0] + 4'h1;
    assign byteVal = (nvRdAddr == 16'hFFBF) ? optByte :
                     (nvRdAddr == 16'hFFBD) ? 8'h5A : {keyNib, keyNib};
    // Between answers the data lines show the addressed byte inverted.
    assign nvRdValid = nvRdReq && waitCnt_q == lag;
    assign nvRdData = nvRdValid ? byteVal : ~byteVal;
    // Counts wait cycles; an unknown request clears it so it never sticks at X.
    always_ff @(posedge ref_clk) begin
        if (nvRdReq === 1'b1 && !nvRdValid) begin
            waitCnt_q <= waitCnt_q + 2'h1;
        end else begin
            waitCnt_q <= 2'h0;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/fsk_sec_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsk_sec_assertions (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Bus handshake.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Array read port.
    input wire logic nvRdReq,
    input wire logic [15:0] nvRdAddr,
    input wire logic [7:0] nvRdData,
    input wire logic nvRdValid,
    // Gates and state.
    input wire logic ramReq,
    input wire logic ramFromDebug,
    input wire logic ramFromSecureCode,
    input wire logic ramAllow,
    input wire logic dbgCmdValid,
    input wire logic [7:0] dbgCmdCode,
    input wire logic dbgCmdAccept,
    input wire logic dbgCmdAccessErr,
    input wire logic blankCheckPass,
    input wire logic securedOut,
    input wire logic vectorRedirectDisable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [7:0] optCap_q;
    logic optTake;
    logic bothOk;
    // Keeps the fetched option byte; reset parks it at key-enabled so no stale check runs.
    assign optTake = nvRdReq && nvRdValid && nvRdAddr == 16'hFFBF;
    assign bothOk = dbgCmdCode == 8'h05 || dbgCmdCode == 8'h41;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            optCap_q <= 8'h80;
        end else if (optTake) begin
            optCap_q <= nvRdData;
        end
    end
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ram_gate: assert property (ramAllow == (ramReq && (!securedOut ||
        (!ramFromDebug && ramFromSecureCode)))) else $error("ram gate wrong");
    a_dbg_refused: assert property (dbgCmdValid && securedOut && !bothOk |=>
        dbgCmdAccessErr && !dbgCmdAccept) else $error("secured command not refused");
    a_dbg_allowed: assert property (dbgCmdValid && bothOk |=>
        dbgCmdAccept && !dbgCmdAccessErr) else $error("erase or blank check refused");
    a_reset_state: assert property ($fell(reset) |->
        securedOut && nvRdReq && nvRdAddr == 16'hFFB0) else $error("bad state after reset");
    a_load_order: assert property (nvRdReq && nvRdValid && nvRdAddr[15:3] == 13'h1FF6 &&
        nvRdAddr[2:0] != 3'h7 |=> nvRdAddr == $past(nvRdAddr) + 16'h1)
        else $error("key fetch order wrong");
    a_load_stops: assert property (optTake |=> !nvRdReq [*2])
        else $error("loader kept fetching");
    a_opt_copy: assert property (optTake |-> ##3 vectorRedirectDisable == optCap_q[6] &&
        securedOut == (optCap_q[1:0] != fsk_pkg::SEC_UNSECURED)) else $error("option copy wrong");
    a_key_disabled: assert property (securedOut && !optCap_q[7] && !nvRdReq &&
        optCap_q[1:0] != 2'h2 && !blankCheckPass |=> securedOut) else $error("unsecured w/o key");
    c_unlock: cover property ($fell(securedOut));
    c_refuse: cover property (dbgCmdAccessErr);
    c_ram_debug: cover property (ramReq && ramFromDebug && ramAllow);
endmodule
bind fsk_security_unit fsk_sec_assertions chk_u (.ref_clk(ref_clk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .nvRdReq(nvRdReq),
    .nvRdAddr(nvRdAddr), .nvRdData(nvRdData), .nvRdValid(nvRdValid), .ramReq(ramReq),
    .ramFromDebug(ramFromDebug), .ramFromSecureCode(ramFromSecureCode), .ramAllow(ramAllow),
    .dbgCmdValid(dbgCmdValid), .dbgCmdCode(dbgCmdCode), .dbgCmdAccept(dbgCmdAccept),
    .dbgCmdAccessErr(dbgCmdAccessErr), .blankCheckPass(blankCheckPass),
    .securedOut(securedOut), .vectorRedirectDisable(vectorRedirectDisable));
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, busFromDebug = 1'b0;
    logic [17:0] wbAdr = 18'h0;
    logic [31:0] wbDat = 32'h0, wbDatO, rd;
    logic busCodeSecure = 1'b1, ramReq = 1'b0, ramFromDebug = 1'b0, ramFromSecureCode = 1'b0;
    logic dbgCmdValid = 1'b0, massEraseDone = 1'b0, blankCheckPass = 1'b0;
    logic [7:0] dbgCmdCode = 8'h0, optByte = 8'h83, nvRdData;
    logic [1:0] lag = 2'h0;
    logic nvRdReq, nvRdValid, ramAllow, dbgAcc, dbgErr, securedOut, protDis, vecRed;
    logic [15:0] nvRdAddr;
    logic [6:0] protStart;
    // The last code is outside the command set and is refused in every state.
    logic [7:0] codes [6] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h33};
    int failCount = 0;
    int checkCount = 0;
    always #50 ref_clk = ~ref_clk;
    fsk_security_unit dut_u (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(4'hF),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .busFromDebug(busFromDebug),
        .busCodeSecure(busCodeSecure), .nvRdReq(nvRdReq), .nvRdAddr(nvRdAddr),
        .nvRdData(nvRdData), .nvRdValid(nvRdValid), .ramReq(ramReq), .ramFromDebug(ramFromDebug),
        .ramFromSecureCode(ramFromSecureCode), .ramAllow(ramAllow), .dbgCmdValid(dbgCmdValid),
        .dbgCmdCode(dbgCmdCode), .dbgCmdAccept(dbgAcc), .dbgCmdAccessErr(dbgErr),
        .massEraseDone(massEraseDone), .blankCheckPass(blankCheckPass), .securedOut(securedOut),
        .protectStartField(protStart), .protectDisableBit(protDis),
        .vectorRedirectDisable(vecRed));
    fsk_nv_array_model arr_u (.ref_clk(ref_clk), .nvRdReq(nvRdReq), .nvRdAddr(nvRdAddr),
        .nvRdData(nvRdData), .nvRdValid(nvRdValid), .optByte(optByte), .lag(lag));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle: request held until ack is sampled high, released at that edge.
    // The trailing half cycle lets callers look at outputs once the write has settled.
    task automatic bus(input logic we, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbDat <= {24'h0, wd};
        @(posedge ref_clk);
        while (wbAck !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (wbAck !== 1'b1) begin
            failCount++;
            $display("[FAIL] %0t no bus acknowledge", $time);
        end
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rdChk(input logic [15:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask
    task automatic restart(input logic [7:0] opt, input logic [1:0] l);
        int n;
        n = 0;
        @(posedge ref_clk);
        reset <= 1'b1;
        optByte <= opt;
        lag <= l;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        do begin
            bus(1'b0, 16'h1830, 8'h00);
            n++;
        end while (rd[4] !== 1'b1 && n < 30);
    endtask
    // Opens key access, writes all eight slots, then closes access to compare.
    task automatic keyTry(input logic [7:0] flip);
        bus(1'b1, 16'h1823, 8'h20);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 16'hFFB0 + 16'(i), {2{4'(i + 1)}} ^ (i == 7 ? flip : 8'h00));
        end
        bus(1'b1, 16'h1823, 8'h00);
    endtask
    task automatic dbgLoop(input logic sec);
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            dbgCmdValid <= 1'b1;
            dbgCmdCode <= codes[i];
            @(posedge ref_clk);
            dbgCmdValid <= 1'b0;
            @(negedge ref_clk);
            chk({dbgAcc, dbgErr}, {i < 5 && (!sec || i == 0 || i == 4),
                i == 5 || (sec && i != 0 && i != 4)});
        end
    endtask
    task automatic ram(input logic d, input logic s, input logic exp);
        @(posedge ref_clk);
        ramReq <= 1'b1;
        ramFromDebug <= d;
        ramFromSecureCode <= s;
        @(negedge ref_clk);
        chk(ramAllow, exp);
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        failCount++;
        conclude();
    end
    initial begin
        restart(8'hC3, 2'h0);
        rdChk(16'h1821, 32'hC3);
        rdChk(16'h1824, 32'h5A);
        rdChk(16'hFFBD, 32'h5A);
        rdChk(16'hFFBF, 32'hC3);
        chk({securedOut, vecRed, protStart, protDis}, {2'b11, 7'h2D, 1'b0});
        bus(1'b1, 16'h1821, 8'h00);
        rdChk(16'h1821, 32'hC3);
        bus(1'b1, 16'h1824, 8'hA5);
        chk({protStart, protDis}, {7'h52, 1'b1});
        bus(1'b1, 16'h1822, 8'hFF);
        rdChk(16'h1822, 32'h0);
        dbgLoop(1'b1);
        ram(1'b1, 1'b1, 1'b0);
        ram(1'b0, 1'b0, 1'b0);
        ram(1'b0, 1'b1, 1'b1);
        // A correct key from the debug port must be refused.
        busFromDebug <= 1'b1;
        keyTry(8'h00);
        busFromDebug <= 1'b0;
        bus(1'b0, 16'h1830, 8'h00);
        chk(rd & 32'h1B, 32'h19);
        bus(1'b1, 16'h1830, 8'h08);
        bus(1'b0, 16'h1830, 8'h00);
        chk(rd & 32'h08, 32'h0);
        keyTry(8'h01);
        bus(1'b0, 16'h1830, 8'h00);
        chk(rd & 32'h07, 32'h05);
        keyTry(8'h00);
        bus(1'b0, 16'h1830, 8'h00);
        chk({rd[1:0], securedOut}, 3'b100);
        ram(1'b1, 1'b0, 1'b1);
        dbgLoop(1'b0);
        // Every security field value with the key switched off.
        for (int s = 0; s < 4; s++) begin
            restart({6'h0, 2'(s)}, 2'(s));
            chk(securedOut, s != 2);
        end
        keyTry(8'h00);
        chk(securedOut, 1'b1);
        @(posedge ref_clk);
        massEraseDone <= 1'b1;
        @(posedge ref_clk);
        massEraseDone <= 1'b0;
        blankCheckPass <= 1'b1;
        @(posedge ref_clk);
        blankCheckPass <= 1'b0;
        @(negedge ref_clk);
        chk(securedOut, 1'b0);
        rdChk(16'h1830, 32'h30);
        conclude();
    end
endmodule
`default_nettype wire
